// file: include/pdrc_pkg.sv
// =============================================================
// Shared constants and carriers for the power-down and reset control.
package pdrc_pkg;

    // Sizes of the device and of the register bus.
    localparam int NUM_MC   = 32;   // Macrocell registers and outputs.
    localparam int NUM_IN   = 4;    // Dedicated input pins.
    localparam int ADDR_W   = 8;    // Byte address width of the register port.
    localparam int DATA_W   = 32;   // Register data width.
    localparam int SIG_BITS = 160;  // User signature length.
    localparam int SIG_WORDS = SIG_BITS / DATA_W;

    // Clock rate and documented times.
    localparam int CLK_MHZ     = 50;   // Core clock, 20 ns period.
    localparam int POR_TIME_US = 10;   // Power-up clear interval, longest figure.
    localparam int WAKE_TIME_US = 1;   // Sleep pin low to valid outputs.
    localparam int POR_CYC  = POR_TIME_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_TIME_US * CLK_MHZ;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SLEW    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PL_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PL_VAL  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FUSE    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MC_Q    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SIG0    = 8'h20;

    // Field positions.
    localparam int CTRL_PD_EN_BIT  = 0;
    localparam int FUSE_SET_BIT    = 0;
    localparam int ST_ASLEEP_BIT   = 0;
    localparam int ST_POR_BIT      = 1;
    localparam int ST_FUSE_BIT     = 2;
    localparam int ST_PRELOAD_BIT  = 3;

    // Reset values.
    localparam logic [DATA_W-1:0] SLEW_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MC_RST     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OE_N_RST   = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] SIG_RST    = 32'h0000_0000;

    // One register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pdrc_bus_req_t;

    // What the logic array hands to the macrocells each cycle.
    typedef struct packed {
        logic [NUM_MC-1:0] next_q;
        logic [NUM_MC-1:0] next_oe_n;
        logic              clk_en;
    } pdrc_array_t;

endpackage

// file: design/pdrc_top.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pdrc_top
    import pdrc_pkg::*;
#(
    parameter int N_MC = NUM_MC,
    parameter int N_IN = NUM_IN
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire pdrc_bus_req_t       bus_req,
    output logic [DATA_W-1:0]        bus_rdata,
    input  wire logic [N_IN-1:0]     in_pin,
    input  wire logic                sleep_request_pin,
    input  wire logic                preload_hv_pin,
    input  wire pdrc_array_t         array_out,
    output logic [N_IN-1:0]          array_in,
    output logic                     array_sleep_bit,
    output logic [N_MC-1:0]          mc_q,
    output logic [N_MC-1:0]          out_oe_n,
    output logic [N_MC-1:0]          slew_fast,
    output logic                     asleep,
    output logic                     outputs_valid,
    output logic                     por_busy
);

    // =============================================================
    // Pin synchronisers
    // Raw pins pass three flops; a level is accepted only when the
    // second and third agree, which also rejects a one-cycle glitch.
    localparam int NS = N_IN + 2;

    logic [NS-1:0] pin_raw;     // Gathered asynchronous pins.
    logic [NS-1:0] sync1_q;     // First stage, read only by the second.
    logic [NS-1:0] sync2_q;     // Second stage.
    logic [NS-1:0] sync3_q;     // Third stage.
    logic [NS-1:0] filt_q;      // Accepted pin levels.
    logic [NS-1:0] filt_d;      // Next accepted levels.

    assign pin_raw = {preload_hv_pin, sleep_request_pin, in_pin};

    // Per bit, take the new level only once two stages agree.
    assign filt_d = (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & filt_q);

    // The synchroniser chain itself.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q  <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    wire logic [N_IN-1:0] in_filt    = filt_q[N_IN-1:0];  // Accepted data inputs.
    wire logic            sleep_filt = filt_q[N_IN];      // Accepted sleep request.
    wire logic            hv_filt    = filt_q[N_IN+1];    // Accepted preload mode.

    // =============================================================
    // Power-up clear
    // The counter stands in for the supply ramp; while it runs all
    // macrocells are forced low and the array clock is ignored.
    localparam int PW = $clog2(POR_CYC + 1);

    logic [PW-1:0] por_cnt_q;   // Cycles left in the clear interval.
    logic [PW-1:0] por_cnt_d;   // Next count.

    assign por_cnt_d = (por_cnt_q != '0) ? por_cnt_q - PW'(1) : por_cnt_q;
    assign por_busy  = (por_cnt_q != '0);

    // Load the full interval on reset and count down to zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_q <= PW'(POR_CYC);
        end else begin
            por_cnt_q <= por_cnt_d;
        end
    end

    // =============================================================
    // Configuration registers
    logic              pd_en_q;     // Sleep feature enabled.
    logic [N_MC-1:0]   slew_q;      // One means fast edges.
    logic [N_MC-1:0]   pl_mask_q;   // Registers picked for preload.
    logic              fuse_q;      // Security fuse programmed.
    logic [DATA_W-1:0] sig_q [SIG_WORDS];  // User signature words.

    // Address decode.
    wire logic wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
    wire logic wr_slew = bus_req.wr && (bus_req.addr == OFS_SLEW);
    wire logic wr_mask = bus_req.wr && (bus_req.addr == OFS_PL_MASK);
    wire logic wr_pval = bus_req.wr && (bus_req.addr == OFS_PL_VAL);
    wire logic wr_fuse = bus_req.wr && (bus_req.addr == OFS_FUSE);

    // The fuse is one-way: once set only a full reset clears it, so a
    // programmer must leave it for last because it bites at once.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_en_q   <= 1'b0;
            slew_q    <= N_MC'(SLEW_RST);
            pl_mask_q <= '0;
            fuse_q    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                pd_en_q <= bus_req.wdata[CTRL_PD_EN_BIT];
            end
            if (wr_slew) begin
                slew_q <= bus_req.wdata[N_MC-1:0];
            end
            if (wr_mask) begin
                pl_mask_q <= bus_req.wdata[N_MC-1:0];
            end
            if (wr_fuse && bus_req.wdata[FUSE_SET_BIT]) begin
                fuse_q <= 1'b1;
            end
        end
    end

    // True when the address picks signature word idx. The write strobes
    // and the read mux share this one decode, so the two can never
    // disagree about where a word lives.
    function automatic logic sig_addr_hit(input logic [ADDR_W-1:0] a,
                                          input int              idx);
        return a == (OFS_SIG0 + ADDR_W'(4 * idx));
    endfunction

    // Signature words, one per aligned word after the first offset.
    for (genvar g = 0; g < SIG_WORDS; g++) begin : g_sig
        wire logic wr_sig = bus_req.wr && sig_addr_hit(bus_req.addr, g);
        // Store a signature word.
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                sig_q[g] <= SIG_RST;
            end else if (wr_sig) begin
                sig_q[g] <= bus_req.wdata;
            end
        end
    end

    assign slew_fast = slew_q;

    // =============================================================
    // Sleep control
    // Sleep follows the accepted pin only while the feature is on.
    logic asleep_q;             // Device in low-current sleep.
    wire logic asleep_d = pd_en_q && sleep_filt;

    // Register the sleep state; leaving takes one cycle, well under
    // the wake budget.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            asleep_q <= 1'b0;
        end else begin
            asleep_q <= asleep_d;
        end
    end

    assign asleep        = asleep_q;
    assign outputs_valid = !asleep_q && !por_busy;

    // While the feature is on the pin never reaches the array.
    assign array_sleep_bit = pd_en_q ? 1'b0 : sleep_filt;

    // =============================================================
    // Input hold latches
    // During sleep the array keeps the last accepted pin values, so
    // nothing downstream sees a floating or changing level.
    logic [N_IN-1:0] in_hold_q;  // Levels presented to the array.

    // Capture inputs only while awake.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_hold_q <= '0;
        end else if (!asleep_q) begin
            in_hold_q <= in_filt;
        end
    end

    assign array_in = in_hold_q;

    // =============================================================
    // Macrocell registers and output enables
    // Preload needs the high-voltage pin, an unfused part and an awake
    // device; a write outside those conditions is silently dropped.
    wire logic pl_mode = hv_filt && !fuse_q;
    wire logic pl_go   = wr_pval && pl_mode && !asleep_q;
    wire logic mc_clk  = array_out.clk_en && !asleep_q;

    logic [N_MC-1:0] mc_q_r;     // Macrocell register state.
    logic [N_MC-1:0] mc_d;       // Next macrocell state.
    logic [N_MC-1:0] oe_n_q;     // Held output enables, low drives.
    logic [N_MC-1:0] oe_n_d;     // Next output enables.

    assign mc_d = por_busy ? N_MC'(MC_RST) :
                  pl_go    ? (mc_q_r & ~pl_mask_q) |
                             (bus_req.wdata[N_MC-1:0] & pl_mask_q) :
                  mc_clk   ? array_out.next_q : mc_q_r;

    // A disabled output at sleep entry stays disabled: nothing moves.
    assign oe_n_d = asleep_q ? oe_n_q : array_out.next_oe_n;

    // Registers update from the chosen source.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_q_r <= N_MC'(MC_RST);
            oe_n_q <= N_MC'(OE_N_RST);
        end else begin
            mc_q_r <= mc_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign mc_q     = mc_q_r;
    assign out_oe_n = oe_n_q;

    // =============================================================
    // Read path
    // Readback of the macrocell pattern is blanked once fused; the
    // signature is not, so a part can still be identified.
    logic [DATA_W-1:0] rd_mux;    // Selected read word.
    logic [DATA_W-1:0] rdata_q;   // Read data, valid one cycle.
    logic [DATA_W-1:0] status_w;  // Status word.
    logic [DATA_W-1:0] sig_w;     // Addressed signature word.
    logic              sig_hit;   // Address falls in the signature.

    assign status_w = DATA_W'({pl_mode, fuse_q, por_busy, asleep_q});

    // Pick the signature word, if any, for the current address.
    always_comb begin
        sig_w   = '0;
        sig_hit = 1'b0;
        for (int i = 0; i < SIG_WORDS; i++) begin
            if (sig_addr_hit(bus_req.addr, i)) begin
                sig_w   = sig_q[i];
                sig_hit = 1'b1;
            end
        end
    end

    // Main read decode; unmapped addresses read as zero.
    always_comb begin
        unique case (bus_req.addr)
            OFS_CTRL:    rd_mux = fuse_q ? '0 : DATA_W'(pd_en_q);
            OFS_SLEW:    rd_mux = fuse_q ? '0 : DATA_W'(slew_q);
            OFS_PL_MASK: rd_mux = DATA_W'(pl_mask_q);
            OFS_FUSE:    rd_mux = DATA_W'(fuse_q);
            OFS_STATUS:  rd_mux = status_w;
            OFS_MC_Q:    rd_mux = fuse_q ? '0 : DATA_W'(mc_q_r);
            default:     rd_mux = sig_hit ? sig_w : '0;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= bus_req.rd ? rd_mux : '0;
        end
    end

    assign bus_rdata = rdata_q;

    // =============================================================
    // Assertions
    localparam int WAKE_BOUND = WAKE_CYC;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sleep_two;
        asleep_q ##1 asleep_q;
    endsequence

    por_clear_a: assert property (por_busy |=> mc_q_r == '0)
        else $error("macrocell not low during power-up clear");
    sleep_enter_a: assert property (pd_en_q && sleep_filt |=> asleep_q)
        else $error("enabled sleep request did not enter sleep");
    state_hold_a: assert property (s_sleep_two |-> $stable(mc_q_r))
        else $error("macrocell state moved during sleep");
    hiz_hold_a: assert property (s_sleep_two |-> $stable(oe_n_q))
        else $error("output enable moved during sleep");
    input_hold_a: assert property (s_sleep_two |-> $stable(in_hold_q))
        else $error("array inputs moved during sleep");
    pin_mask_a: assert property (pd_en_q |-> !array_sleep_bit)
        else $error("sleep pin reached the array while enabled");
    wake_time_a: assert property ($fell(sleep_filt) |-> ##[1:WAKE_BOUND] outputs_valid || por_busy)
        else $error("outputs not valid after wake");
    preload_a: assert property (pl_go && !por_busy |=> mc_q_r == (($past(mc_q_r) & $past(pl_mask_q)) ^ $past(mc_q_r) | ($past(bus_req.wdata[N_MC-1:0]) & $past(pl_mask_q))))
        else $error("preload did not force selected registers");
    fuse_read_a: assert property (fuse_q && bus_req.rd && bus_req.addr == OFS_MC_Q |=> bus_rdata == '0)
        else $error("readback not blanked after fuse");
    sig_read_a: assert property (bus_req.rd && bus_req.addr == OFS_SIG0 |=> bus_rdata == $past(sig_q[0]))
        else $error("signature word unreadable");
    no_sleep_a: assert property (!pd_en_q |=> !asleep_q || $past(pd_en_q) == 1'b0 && !asleep_q)
        else $error("sleep entered with feature disabled");

    // Feature off for two cycles: any asleep flag has drained, so a
    // clocked array must load exactly as if the pin did not exist.
    sequence s_feat_off;
        !pd_en_q ##1 (!pd_en_q && array_out.clk_en && !pl_go && !por_busy);
    endsequence

    // A preload write that the mode or the fuse refuses, with no array
    // clock beside it, must leave every macrocell where it was.
    sequence s_pl_refused;
        wr_pval && !pl_mode && !mc_clk && !por_busy;
    endsequence

    feat_off_a: assert property (s_feat_off |=> mc_q_r == $past(array_out.next_q))
        else $error("array load lost with sleep feature disabled");
    pl_refuse_a: assert property (s_pl_refused |=> $stable(mc_q_r))
        else $error("refused preload changed a macrocell");
    wake_exit_a: assert property ($fell(sleep_filt) |=> !asleep_q)
        else $error("sleep not left one cycle after the pin fell");
    input_track_a: assert property (!asleep_q |=> in_hold_q == $past(in_filt))
        else $error("awake array inputs missed a pin change");

endmodule

`default_nettype wire

// file: verification/pdrc_sys_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// System logic beside the device: inputs, array and sleep pin.
module pdrc_sys_model
    import pdrc_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               por_busy,
    input  wire logic               sleep_go,
    input  wire logic               clk_go,
    input  wire logic [DATA_W-1:0]  data_word,
    output logic [NUM_IN-1:0]       in_pin,
    output logic                    sleep_request_pin,
    output pdrc_array_t             array_out
);
    // Inputs stay frozen for one cycle, starting on the edge where the pin rises.
    wire hold_w = sleep_go && !sleep_request_pin;

    // The model is no kinder than real logic: it keeps changing
    // every input while asleep, so the device must ignore them.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_pin            <= '0;
            sleep_request_pin <= 1'b0;
            array_out         <= '0;
        end else begin
            sleep_request_pin <= sleep_go;
            if (!hold_w) begin
                in_pin              <= data_word[NUM_IN-1:0];
                array_out.next_q    <= data_word;
                array_out.next_oe_n <= ~data_word;
                // No clock until the power-up clear is over.
                array_out.clk_en    <= clk_go && !por_busy;
            end
        end
    end
endmodule

`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the power-down and reset control.
module tb_top
    import pdrc_pkg::*;
;

    logic                core_clk, rst_n, preload_hv_pin;
    logic                sleep_go, clk_go;          // Model controls.
    pdrc_bus_req_t       bus_req;                   // Register port.
    pdrc_array_t         array_out;
    logic [DATA_W-1:0]   bus_rdata, rnd_q, rd_v, e, q, oe, m, v;
    logic [DATA_W-1:0]   sig_exp [SIG_WORDS];       // Signature copy.
    logic [NUM_IN-1:0]   in_pin, array_in, ai;
    logic [NUM_MC-1:0]   mc_q, out_oe_n, slew_fast;
    logic                sleep_request_pin, array_sleep_bit;
    logic                asleep, outputs_valid, por_busy;
    int                  fail_count, num_checks, cyc, t0, n;

    pdrc_top dut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .in_pin(in_pin), .sleep_request_pin(sleep_request_pin),
        .preload_hv_pin(preload_hv_pin), .array_out(array_out), .array_in(array_in),
        .array_sleep_bit(array_sleep_bit), .mc_q(mc_q), .out_oe_n(out_oe_n),
        .slew_fast(slew_fast), .asleep(asleep), .outputs_valid(outputs_valid),
        .por_busy(por_busy));

    pdrc_sys_model sys (.core_clk(core_clk), .rst_n(rst_n), .por_busy(por_busy),
        .sleep_go(sleep_go), .clk_go(clk_go), .data_word(rnd_q), .in_pin(in_pin),
        .sleep_request_pin(sleep_request_pin), .array_out(array_out));

    // ======================================================
    // Clock, random source and hang guard.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Xorshift keeps the run repeatable from one seed.
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Value a preload should leave: masked bits come from the new word.
    function automatic logic [31:0] pl_exp(input logic [31:0] old_v, mask_v, val_v);
        return (old_v & ~mask_v) | (val_v & mask_v);
    endfunction

    // A fresh word each cycle feeds the model's data inputs.
    always @(posedge core_clk) begin
        rnd_q <= xs(rnd_q);
        cyc   <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ======================================================
    // Checking and bus tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // ======================================================
    // Main sequence.
    initial begin
        rnd_q = 32'h0000_f8dc;
        cyc = 0; fail_count = 0; num_checks = 0;
        rst_n = 1'b0; bus_req = '0; preload_hv_pin = 1'b0;
        sleep_go = 1'b0; clk_go = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        t0 = cyc;
        #1 chk(out_oe_n, OE_N_RST, "oe reset");
        chk(slew_fast, SLEW_RST, "slew default");
        rd(OFS_STATUS, rd_v);
        chk(32'(rd_v[ST_POR_BIT]), 32'h1, "por status");
        e = '0;
        // Any register seen high during the clear is an error.
        for (n = 0; por_busy === 1'b1 && n < 1000; n++) begin
            @(posedge core_clk);
            #1 e |= mc_q;
        end
        chk(e, MC_RST, "clear low");
        chk(32'((cyc - t0) >= POR_CYC - 2 && (cyc - t0) <= POR_CYC + 2), 32'h1, "por len");
        @(posedge core_clk);
        clk_go <= 1'b1;
        sleep_go <= 1'b1;
        // Feature off: the pin is raised but the array keeps running.
        repeat (10) @(posedge core_clk);
        for (n = 0; n < 8; n++) begin
            #1 e = array_out.next_q;
            @(posedge core_clk);
            #1 chk(mc_q, e, "array clocked");
            chk(32'(asleep), 32'h0, "no sleep");
            chk(32'(array_sleep_bit), 32'h1, "pin as array input");
        end
        v = rnd_q;
        wr(OFS_SLEW, v);
        rd(OFS_SLEW, rd_v);
        chk(rd_v, v, "slew readback");
        chk(slew_fast, v, "slew per output");
        @(posedge core_clk);
        sleep_go <= 1'b0;
        // Let the accepted pin settle low before the feature goes on,
        // or the old high level would put the device to sleep early.
        repeat (6) @(posedge core_clk);
        wr(OFS_CTRL, 32'h1);
        @(posedge core_clk);
        sleep_go <= 1'b1;
        for (n = 0; asleep !== 1'b1 && n < 20; n++)
            @(posedge core_clk);
        #1 chk(32'(asleep), 32'h1, "asleep");
        chk(32'(array_sleep_bit), 32'h0, "pin not array input");
        q = mc_q; oe = out_oe_n; ai = array_in;
        repeat (30) @(posedge core_clk);
        #1 chk(mc_q, q, "state held");
        chk(out_oe_n, oe, "hi-z held");
        chk(32'(array_in), 32'(ai), "inputs blocked");
        chk(32'(outputs_valid), 32'h0, "valid low asleep");
        @(posedge core_clk);
        sleep_go <= 1'b0;
        for (n = 0; outputs_valid !== 1'b1 && n < WAKE_CYC + 10; n++)
            @(posedge core_clk);
        chk(32'(n <= WAKE_CYC + 1), 32'h1, "wake time");
        @(posedge core_clk);
        clk_go <= 1'b0;
        // Without the high-voltage pin a preload write must do nothing.
        repeat (2) @(posedge core_clk);
        #1 q = mc_q;
        wr(OFS_PL_MASK, 32'hffff_ffff);
        wr(OFS_PL_VAL, ~q);
        #1 chk(mc_q, q, "preload needs hv");
        @(posedge core_clk);
        preload_hv_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(OFS_STATUS, rd_v);
        chk(32'(rd_v[ST_PRELOAD_BIT]), 32'h1, "preload mode");
        for (int i = 0; i < 4; i++) begin
            #1 m = (i == 0) ? 32'h8000_0001 : rnd_q;
            v = xs(m);
            q = mc_q;
            wr(OFS_PL_MASK, m);
            wr(OFS_PL_VAL, v);
            rd(OFS_MC_Q, rd_v);
            chk(rd_v, pl_exp(q, m, v), "preload read");
            chk(mc_q, pl_exp(q, m, v), "preload pins");
        end
        for (int i = 0; i < SIG_WORDS; i++) begin
            sig_exp[i] = xs(rnd_q + 32'(i));
            wr(OFS_SIG0 + 8'(4 * i), sig_exp[i]);
        end
        wr(OFS_FUSE, 32'h1);
        rd(OFS_STATUS, rd_v);
        chk(32'(rd_v[ST_FUSE_BIT]), 32'h1, "fuse set");
        rd(OFS_CTRL, rd_v);
        chk(rd_v, 32'h0, "ctrl locked");
        rd(OFS_SLEW, rd_v);
        chk(rd_v, 32'h0, "slew locked");
        rd(OFS_MC_Q, rd_v);
        chk(rd_v, 32'h0, "state locked");
        q = mc_q;
        wr(OFS_PL_MASK, 32'hffff_ffff);
        wr(OFS_PL_VAL, ~q);
        #1 chk(mc_q, q, "preload refused");
        for (int i = 0; i < SIG_WORDS; i++) begin
            rd(OFS_SIG0 + 8'(4 * i), rd_v);
            chk(rd_v, sig_exp[i], "signature");
        end
        rd(8'h40, rd_v);
        chk(rd_v, 32'h0, "unmapped");
        tally_and_finish();
    end
endmodule

`default_nettype wire
